// File: hw/pcg_top.v
// peripheral clock gating control with apb registers and fault detection
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pcg_consts.vh"

// Overview of operation
// - a set enable bit passes the clock to its peripheral and a clear bit stops it.
// - an access to a peripheral whose clock is gated off is answered with a bus fault.
// - after reset every enable bit is clear so all peripherals start unclocked.
// - each gating register is 32 bits, resets to zero, and reserved bits read zero.
// - run, sleep and deep-sleep modes each use their own gating register.
// - sleep and deep-sleep registers apply only when automatic clock gating is set.
// - bits 18, 17 and 16 gate general-purpose timers two, one and zero.
// - bit 12 gates the two-wire controller and bit 4 the synchronous serial port.
// - bit 1 gates asynchronous serial port one and bit 0 port zero.
// - the deep-sleep gating register sits at 0x124 with the same layout and reset.
module pcg_top
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        periph_access,
  input  wire [6:0]  periph_select,
  output reg         periph_fault,
  output reg  [6:0]  periph_clk_en,
  output wire [6:0]  periph_clk,
  output reg         irq
);

  // ********************************************************************
  // register state
  // ********************************************************************
  // software-visible registers, then the mode and read mux results
  reg  [31:0] run_gate_q;
  reg  [31:0] sleep_gate_q;
  reg  [31:0] dsleep_gate_q;
  reg  [31:0] clk_config_q;
  reg  [1:0]  power_mode_q;
  reg  [0:0]  irq_status_q;
  reg  [0:0]  irq_mask_q;
  reg  [31:0] active_gate_d;
  reg  [31:0] rdata_d;
  reg         addr_hit_d;
  // bus phase decode nets, the fault flag and the enable vector
  wire        setup_ph;
  wire        wr_ph;
  wire        rd_ph;
  wire        fault_now;
  wire [6:0]  en_vec;
  // per-register write strobes and the status read strobe
  wire        wr_run_gate;
  wire        wr_sleep_gate;
  wire        wr_dsleep_gate;
  wire        wr_clk_config;
  wire        wr_power_mode;
  wire        wr_irq_mask;
  wire        rd_irq_status;

  // pack the seven used bits of a gating word into a peripheral vector
  function [6:0] pack_gate;
    input [31:0] word;
    begin
      pack_gate = {word[`PCG_BIT_GPTIMER_TWO],
                   word[`PCG_BIT_GPTIMER_ONE],
                   word[`PCG_BIT_GPTIMER_ZERO],
                   word[`PCG_BIT_TWOWIRE_ZERO],
                   word[`PCG_BIT_SYNC_SERIAL],
                   word[`PCG_BIT_ASYNC_ONE],
                   word[`PCG_BIT_ASYNC_ZERO]};
    end
  endfunction

  // true when the bus address selects the given register offset
  function reg_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      reg_hit = (addr == off);
    end
  endfunction

  // merge write data into a register under byte strobes and a writable mask
  function [31:0] merge_word;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0]  strb;
    input [31:0] wmask;
    reg   [31:0] lane;
    begin
      lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge_word = ((old & ~(lane & wmask)) | (wdata & lane & wmask)) & wmask;
    end
  endfunction

  // ********************************************************************
  // apb decode: zero-wait slave, answer in the access phase
  // ********************************************************************
  assign setup_ph = psel & ~penable;
  assign wr_ph    = psel & penable & pwrite & pready;
  assign rd_ph    = psel & penable & ~pwrite & pready;

  // read mux; reserved bits come back as zero through the masks
  always @*
  begin
    addr_hit_d = 1'b1;
    rdata_d    = 32'h0000_0000;
    case (paddr)
      `PCG_OFF_RUN_GATE:    rdata_d = run_gate_q & `PCG_GATE_WMASK;
      `PCG_OFF_SLEEP_GATE:  rdata_d = sleep_gate_q & `PCG_GATE_WMASK;
      `PCG_OFF_DSLEEP_GATE: rdata_d = dsleep_gate_q & `PCG_GATE_WMASK;
      `PCG_OFF_CLK_CONFIG:  rdata_d = clk_config_q & `PCG_CFG_WMASK;
      `PCG_OFF_POWER_MODE:  rdata_d = {30'h0000_0000, power_mode_q};
      `PCG_OFF_IRQ_STATUS:  rdata_d = {31'h0000_0000, irq_status_q};
      `PCG_OFF_IRQ_MASK:    rdata_d = {31'h0000_0000, irq_mask_q};
      default:              addr_hit_d = 1'b0;
    endcase
  end

  // bus handshake: pready high in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (setup_ph)
    begin
      pready  <= 1'b1;
      pslverr <= ~addr_hit_d;
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ********************************************************************
  // write strobes: one per writable register, only on a completed mapped write
  // ********************************************************************
  assign wr_run_gate    = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_RUN_GATE);
  assign wr_sleep_gate  = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_SLEEP_GATE);
  assign wr_dsleep_gate = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_DSLEEP_GATE);
  assign wr_clk_config  = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_CLK_CONFIG);
  assign wr_power_mode  = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_POWER_MODE);
  assign wr_irq_mask    = wr_ph & ~pslverr & reg_hit(paddr, `PCG_OFF_IRQ_MASK);
  // status read strobe, taken at the access edge
  assign rd_irq_status  = rd_ph & reg_hit(paddr, `PCG_OFF_IRQ_STATUS);

  // ********************************************************************
  // gating and configuration registers
  // ********************************************************************
  // run-mode gating word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_gate_q <= `PCG_GATE_RESET;
    else if (wr_run_gate)
      run_gate_q <= merge_word(run_gate_q, pwdata, pstrb, `PCG_GATE_WMASK);
  end

  // sleep-mode gating word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_gate_q <= `PCG_GATE_RESET;
    else if (wr_sleep_gate)
      sleep_gate_q <= merge_word(sleep_gate_q, pwdata, pstrb, `PCG_GATE_WMASK);
  end

  // deep-sleep gating word, same layout as the others
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dsleep_gate_q <= `PCG_GATE_RESET;
    else if (wr_dsleep_gate)
      dsleep_gate_q <= merge_word(dsleep_gate_q, pwdata, pstrb, `PCG_GATE_WMASK);
  end

  // clock configuration, only the automatic gating bit is kept
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_config_q <= `PCG_CFG_RESET;
    else if (wr_clk_config)
      clk_config_q <= merge_word(clk_config_q, pwdata, pstrb, `PCG_CFG_WMASK);
  end

  // power mode code, written through the lowest byte lane
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      power_mode_q <= `PCG_MODE_RUN;
    else if (wr_power_mode && pstrb[0])
      power_mode_q <= pwdata[1:0];
  end

  // interrupt mask, written through the lowest byte lane
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= 1'b0;
    else if (wr_irq_mask && pstrb[0])
      irq_mask_q <= pwdata[0:0];
  end

  // ********************************************************************
  // mode selection of the active gating word
  // ********************************************************************
  always @*
  begin
    active_gate_d = run_gate_q;
    if (clk_config_q[`PCG_BIT_AUTO_GATE])
    begin
      case (power_mode_q)
        `PCG_MODE_SLEEP:  active_gate_d = sleep_gate_q;
        `PCG_MODE_DSLEEP: active_gate_d = dsleep_gate_q;
        default:          active_gate_d = run_gate_q;
      endcase
    end
  end

  assign en_vec = pack_gate(active_gate_d);

  // registered enables feed the gates and the fault checker
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_clk_en <= 7'h00;
    else
      periph_clk_en <= en_vec;
  end

  // ********************************************************************
  // per-peripheral glitch-free clock gates
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `PCG_NUM_PERIPH; gi = gi + 1)
    begin : g_gate
      pcg_clock_gate u_gate
      (
        .clk_in  (pclk),
        .rst_n   (presetn),
        .enable  (periph_clk_en[gi]),
        .clk_out (periph_clk[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // bus fault on access to an unclocked peripheral
  // ********************************************************************
  pcg_fault_check u_fault
  (
    .access_valid (periph_access),
    .access_sel   (periph_select),
    .clock_on     (periph_clk_en),
    .fault        (fault_now)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_fault <= 1'b0;
    else
      periph_fault <= fault_now;
  end

  // ********************************************************************
  // interrupt: sticky fault status, read clears, set wins
  // ********************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_q <= 1'b0;
    else if (fault_now)
      irq_status_q <= 1'b1;
    else if (rd_irq_status)
      irq_status_q <= irq_status_q & ~prdata[0:0]; // clear only what the read reported
  end

  // a fault landing between setup and access is not lost: prdata missed it,
  // so it stays set for the next read

  // level interrupt while an unmasked status bit is set
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_q & irq_mask_q);
  end

endmodule

// File: common/pcg_consts.vh
// constants for the peripheral clock gating block
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// register byte offsets
`define PCG_OFF_RUN_GATE      12'h104
`define PCG_OFF_SLEEP_GATE    12'h114
`define PCG_OFF_DSLEEP_GATE   12'h124
`define PCG_OFF_CLK_CONFIG    12'h060
`define PCG_OFF_POWER_MODE    12'h064
`define PCG_OFF_IRQ_STATUS    12'h070
`define PCG_OFF_IRQ_MASK      12'h074

// gating register fields
`define PCG_BIT_GPTIMER_TWO   18
`define PCG_BIT_GPTIMER_ONE   17
`define PCG_BIT_GPTIMER_ZERO  16
`define PCG_BIT_TWOWIRE_ZERO  12
`define PCG_BIT_SYNC_SERIAL   4
`define PCG_BIT_ASYNC_ONE     1
`define PCG_BIT_ASYNC_ZERO    0
`define PCG_GATE_WMASK        32'h0007_1013
`define PCG_GATE_RESET        32'h0000_0000

// clock configuration field
`define PCG_BIT_AUTO_GATE     27
`define PCG_CFG_WMASK         32'h0800_0000
`define PCG_CFG_RESET         32'h0000_0000

// power mode field codes
`define PCG_MODE_RUN          2'h0
`define PCG_MODE_SLEEP        2'h1
`define PCG_MODE_DSLEEP       2'h2

// interrupt status bits
`define PCG_IRQ_FAULT         0
`define PCG_IRQ_WIDTH         1

// peripheral count
`define PCG_NUM_PERIPH        7

`endif

// File: hw/pcg_clock_gate.v
// glitch-free latch-free clock gate for one peripheral clock
`timescale 1ns/1ns

module pcg_clock_gate
(
  input  wire clk_in,
  input  wire rst_n,
  input  wire enable,
  output wire clk_out
);

  reg en_low_q;

  // enable is retimed on the falling edge so, apart from an asynchronous reset, it only changes while clk is low
  always @(negedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      en_low_q <= 1'b0;
    else
      en_low_q <= enable;
  end

  // output high phase is a full clk high phase or absent, except when an asynchronous reset clears en_low_q while clk is high
  assign clk_out = clk_in & en_low_q;

endmodule

// File: hw/pcg_fault_check.v
// decides whether a peripheral access must be answered with a bus fault
`timescale 1ns/1ns

module pcg_fault_check
(
  input  wire       access_valid,
  input  wire [6:0] access_sel,
  input  wire [6:0] clock_on,
  output wire       fault
);

  // a selected peripheral whose clock is off faults the access
  assign fault = access_valid & (|(access_sel & ~clock_on));

endmodule

// File: tb/pcg_checker_sva.sv
// assertion checker for the peripheral clock gating block
`timescale 1ns/1ns
module pcg_checker
(
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        periph_access,
  input logic [6:0]  periph_select,
  input logic        periph_fault,
  input logic [6:0]  periph_clk_en,
  input logic [6:0]  periph_clk
);
  wire wr_acc = psel & penable & pready & pwrite;
  wire hit_off = periph_access & (|(periph_select & ~periph_clk_en));
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer timing
  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  // fault on gated peripheral
  fault_gated_a: assert property (hit_off |=> periph_fault)
    else $error("missing bus fault");
  fault_only_gated_a: assert property (!hit_off |=> !periph_fault)
    else $error("spurious bus fault");
  // enables
  en_reset_a: assert property ($rose(presetn) |-> periph_clk_en == 7'h00)
    else $error("enable set after reset");
  en_by_write_a: assert property (!$stable(periph_clk_en) |-> $past(wr_acc, 2))
    else $error("enable changed without write");
  gate_follow_a: assert property (@(negedge pclk) disable iff (!presetn)
    periph_clk == $past(periph_clk_en))
    else $error("gated clock does not follow enable");
  cover property (periph_fault);
  cover property (pslverr);
  cover property (periph_clk_en == 7'h40);
endmodule

bind pcg_top pcg_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_access(periph_access), .periph_select(periph_select), .periph_fault(periph_fault),
  .periph_clk_en(periph_clk_en), .periph_clk(periph_clk));

// File: tb/peripheral_clock_gating_test.sv
// self-checking testbench for the peripheral clock gating block
`timescale 1ns/1ns
module peripheral_clock_gating_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        periph_access = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  periph_select = 7'h00;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, v;
  logic [6:0]  periph_clk_en, periph_clk;
  logic        pready, pslverr, periph_fault, irq;
  logic [32:0] exp_q[$];
  int          miscompares, checks, cyc;
  int          bit_tab[7] = '{18, 17, 16, 12, 4, 1, 0};

  pcg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_access(periph_access),
    .periph_select(periph_select), .periph_fault(periph_fault),
    .periph_clk_en(periph_clk_en), .periph_clk(periph_clk), .irq(irq));

  // clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, expected {pslverr, prdata} noted in the queue
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task chk_en(input logic [6:0] e);
    repeat (2) @(posedge pclk);
    cmp({26'h0, periph_clk_en}, {26'h0, e});
  endtask

  task test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // monitor: compare each completed transfer with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      cmp({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());

  // timeout
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      test_done;
    end
  end

  // main sequence
  initial
  begin
    v = $urandom(20857);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_en(7'h00);
    apb(1'b0, 12'h104, 32'h0, 33'h0);
    apb(1'b0, 12'h114, 32'h0, 33'h0);
    apb(1'b0, 12'h124, 32'h0, 33'h0);
    $display("test reset values done");
    foreach (bit_tab[i])
    begin
      wr(12'h104, 32'h1 << bit_tab[i]);
      apb(1'b0, 12'h104, 32'h0, {1'b0, 32'h1 << bit_tab[i]});
      chk_en(7'h40 >> i);
    end
    v = $urandom;
    wr(12'h104, v & 32'h0007_1013);
    apb(1'b0, 12'h104, 32'h0, {1'b0, v & 32'h0007_1013});
    chk_en({v[18], v[17], v[16], v[12], v[4], v[1], v[0]});
    pstrb <= 4'h4;
    wr(12'h104, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, 12'h104, 32'h0, {1'b0, v & 32'h0000_1013});
    chk_en({3'b000, v[12], v[4], v[1], v[0]});
    $display("test field map done");
    wr(12'h104, 32'h1);
    wr(12'h074, 32'h1);
    v = $urandom;
    periph_access <= 1'b1;
    periph_select <= {v[6:2], 2'b10};
    @(posedge pclk);
    periph_select <= 7'h01;
    @(posedge pclk);
    periph_access <= 1'b0;
    cmp({32'h0, periph_fault}, 33'h1);
    @(posedge pclk);
    cmp({32'h0, periph_fault}, 33'h0);
    cmp({32'h0, irq}, 33'h1);
    apb(1'b0, 12'h070, 32'h0, 33'h1);
    apb(1'b0, 12'h070, 32'h0, 33'h0);
    @(posedge pclk);
    cmp({32'h0, irq}, 33'h0);
    $display("test fault done");
    apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h300, 32'hFFFF_FFFF, {1'b1, 32'h0});
    $display("test unmapped done");
    wr(12'h114, 32'h10);
    wr(12'h124, 32'h4_0000);
    wr(12'h064, 32'h1);
    chk_en(7'h01);
    wr(12'h060, 32'h0800_0000);
    chk_en(7'h04);
    wr(12'h064, 32'h2);
    chk_en(7'h40);
    wr(12'h064, 32'h0);
    chk_en(7'h01);
    $display("test power modes done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_en(7'h00);
    apb(1'b0, 12'h114, 32'h0, 33'h0);
    apb(1'b0, 12'h064, 32'h0, 33'h0);
    $display("test mid-run reset done");
    test_done;
  end
endmodule
